/* File: rtl/sbsp_map.vh */
`ifndef SBSP_MAP_VH
`define SBSP_MAP_VH
// ----------------------------------------
// Organisation defaults (wide option)
// ----------------------------------------
`define SBSP_ADDR_W_WIDE 19
`define SBSP_DATA_W_WIDE 32
`define SBSP_LANES_WIDE 4
// ----------------------------------------
// Narrow option: 1M words of 18 bits
// ----------------------------------------
`define SBSP_ADDR_W_NARROW 20
`define SBSP_DATA_W_NARROW 16
`define SBSP_LANES_NARROW 2
// ----------------------------------------
// Burst counter and timing
// ----------------------------------------
`define SBSP_BURST_W 2
`define SBSP_BURST_ZERO 2'h0
`define SBSP_BURST_ONE 2'h1
`define SBSP_LANE_BITS 8
`define SBSP_FIRST_BEAT_CYC 2'h2
`define SBSP_LATER_BEAT_CYC 2'h1
`define SBSP_ORDER_INTERLEAVED 1'b1
`endif

/* File: rtl/sbsp_burst_ctr.v */
`timescale 1ns/1ns
`include "sbsp_map.vh"
// ----------------------------------------
// Two-bit burst address counter
// ----------------------------------------
module sbsp_burst_ctr (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Control
    input wire load,
    input wire step,
    input wire order_interleaved,
    input wire [1:0] start_bits,
    // Result
    output wire [1:0] low_bits
);
    reg [1:0] start_q; // Loaded low address bits
    reg [1:0] beat_q; // Beat count
    reg order_q; // Order captured at load

    // Next linear address, wraps modulo four
    function [1:0] sbsp_lin;
        input [1:0] s;
        input [1:0] b;
        begin
            sbsp_lin = s + b;
        end
    endfunction

    // Load starts a burst, step advances it
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_q <= `SBSP_BURST_ZERO;
            beat_q <= `SBSP_BURST_ZERO;
            order_q <= `SBSP_ORDER_INTERLEAVED;
        end else if (load) begin
            start_q <= start_bits;
            beat_q <= `SBSP_BURST_ZERO;
            order_q <= order_interleaved;
        end else if (step) begin
            beat_q <= beat_q + `SBSP_BURST_ONE;
        end
    end

    // Interleaved uses xor, linear uses add
    assign low_bits = (order_q == `SBSP_ORDER_INTERLEAVED) ?
        (start_q ^ beat_q) : sbsp_lin(start_q, beat_q);
endmodule

/* File: rtl/sbsp_port.v */
`timescale 1ns/1ns
`include "sbsp_map.vh"
module sbsp_port #(
    parameter ADDR_W = `SBSP_ADDR_W_WIDE,
    parameter DATA_W = `SBSP_DATA_W_WIDE,
    parameter LANES = `SBSP_LANES_WIDE
) (
    // Clock and reset
    input wire CLK,
    input wire NRST,
    // Address, then strobes and chip selects, active low except CHIP_SEL_DEPTH_HI
    input wire [ADDR_W-1:0] ADDR,
    input wire PROC_ADDR_STROBE_N,
    input wire CTRL_ADDR_STROBE_N,
    input wire BURST_ADVANCE_N,
    input wire CHIP_SEL_PIPELINED_N,
    input wire CHIP_SEL_DEPTH_HI,
    input wire CHIP_SEL_DEPTH_LO_N,
    // Write control, active low
    input wire [LANES-1:0] BYTE_WRITE_LANE_N,
    input wire BYTE_WRITE_GATE_N,
    input wire GLOBAL_WRITE_N,
    // Static and asynchronous pins
    input wire BURST_ORDER,
    input wire OUTPUT_EN_N,
    input wire SLEEP_REQUEST,
    // Shared data bus, split into three signals
    input wire [DATA_W-1:0] DQ_IN,
    output wire [DATA_W-1:0] DQ_OUT,
    output wire DQ_OE_N,
    input wire [LANES-1:0] PARITY_IO_IN,
    output wire [LANES-1:0] PARITY_IO_OUT,
    // Status
    output wire SLEEPING,
    output wire BEAT_VALID
);
    // ----------------------------------------
    // Storage and derived widths
    // ----------------------------------------
    // Byte lane width and full word width
    localparam LW = `SBSP_LANE_BITS;
    localparam WW = DATA_W + LANES; // Data plus parity bit per lane
    localparam DEPTH = 1 << ADDR_W;
    // One word: data bits, then one parity bit per lane
    reg [WW-1:0] mem [0:DEPTH-1]; // Array cells

    // ----------------------------------------
    // Input, burst state and read data registers
    // ----------------------------------------
    reg [ADDR_W-1:0] addr_q; // Captured burst address
    reg sel_q; // Captured chip select state
    reg active_q; // Burst in progress
    reg [1:0] wait_q; // Cycles until beat data valid
    reg step_q; // Advance taken at the last edge
    reg [DATA_W-1:0] rdata_q; // Read data register
    reg [LANES-1:0] rpar_q; // Read parity register
    reg rvalid_q; // Read data present

    // ----------------------------------------
    // Input decode
    // ----------------------------------------
    // Processor strobe, low at the pin
    wire strobe_p = !PROC_ADDR_STROBE_N; // Processor strobe
    // Controller strobe, low at the pin
    wire strobe_c = !CTRL_ADDR_STROBE_N; // Controller strobe
    // All three chip selects in their active state
    wire sel_now = !CHIP_SEL_PIPELINED_N && CHIP_SEL_DEPTH_HI && !CHIP_SEL_DEPTH_LO_N;
    // Processor strobe is ignored while pipelined select is off
    wire start = (strobe_p && !CHIP_SEL_PIPELINED_N) || strobe_c;
    // Advance only inside a burst, never on a start edge
    wire burst_advance = !BURST_ADVANCE_N && active_q && !start;
    // Counter output: low address bits of this beat
    wire [1:0] low_bits; // Counter output
    // Upper bits stay as captured for the whole burst
    wire [ADDR_W-1:0] cur_addr = {addr_q[ADDR_W-1:2], low_bits};
    // Sleep follows the pin, no register in the path
    wire asleep = SLEEP_REQUEST;

    // Write lane enables, global write covers all lanes
    function [LANES-1:0] sbsp_lanes;
        input gw_n;
        input bwe_n;
        input [LANES-1:0] bw_n;
        begin
            // Global write covers every lane
            if (!gw_n)
                sbsp_lanes = {LANES{1'b1}};
            // Byte gate passes the lane strobes, low per lane
            else if (!bwe_n)
                sbsp_lanes = ~bw_n;
            // No write on this edge
            else
                sbsp_lanes = {LANES{1'b0}};
        end
    endfunction

    wire [LANES-1:0] wlanes = sbsp_lanes(GLOBAL_WRITE_N, BYTE_WRITE_GATE_N, BYTE_WRITE_LANE_N);
    // Writes land on the beat after address capture
    // Sleep and a restart both block the write
    wire do_write = active_q && sel_q && !asleep && (|wlanes) && !start;

    // ----------------------------------------
    // Beat scheduling
    // ----------------------------------------
    // A beat is due on the edge after a start or after an advance,
    // so a burst that is not advanced stops after its first beat
    wire beat_due = (wait_q != `SBSP_BURST_ZERO) || step_q;
    // Read beat: selected burst, awake, no write lanes, no restart
    wire do_read = active_q && sel_q && !asleep && !(|wlanes) && !start && beat_due;

    // ----------------------------------------
    // Burst counter
    // ----------------------------------------
    // Load on any start, step on an advance;
    // both are held off while the part sleeps
    sbsp_burst_ctr u_ctr (
        .clk(CLK),
        .nrst(NRST),
        .load(start && !asleep),
        .step(burst_advance && !asleep),
        .order_interleaved(BURST_ORDER),
        .start_bits(ADDR[1:0]),
        .low_bits(low_bits)
    );

    // ----------------------------------------
    // Address and select capture
    // ----------------------------------------
    // Strobe edge registers address and selects
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            // No burst open after reset
            addr_q <= {ADDR_W{1'b0}};
            sel_q <= 1'b0;
            active_q <= 1'b0;
            wait_q <= `SBSP_BURST_ZERO;
            step_q <= 1'b0;
        end else if (asleep) begin
            // Sleep ends any burst; a new start is needed after wake
            active_q <= 1'b0;
            wait_q <= `SBSP_BURST_ZERO;
            step_q <= 1'b0;
        end else if (start) begin
            // New access, also when a burst is still running
            addr_q <= ADDR;
            sel_q <= sel_now;
            active_q <= 1'b1;
            wait_q <= `SBSP_FIRST_BEAT_CYC - `SBSP_LATER_BEAT_CYC;
            step_q <= 1'b0;
        end else begin
            // Remember an advance so the next edge reads a beat
            step_q <= burst_advance;
            // First beat takes two clocks, later ones one
            if (wait_q != `SBSP_BURST_ZERO) begin
                wait_q <= wait_q - `SBSP_BURST_ONE;
            end
        end
    end

    // ----------------------------------------
    // Array access, one beat per clock
    // ----------------------------------------
    // Lane index for the byte loop
    integer i;
    // Byte-lane write into the array
    always @(posedge CLK) begin
        if (do_write) begin
            for (i = 0; i < LANES; i = i + 1) begin
                // Only lanes picked by the write controls change
                if (wlanes[i]) begin
                    // Parity bit of the lane travels with its byte
                    mem[cur_addr][i*LW +: LW] <= DQ_IN[i*LW +: LW];
                    mem[cur_addr][DATA_W+i] <= PARITY_IO_IN[i];
                end
            end
        end
    end

    // Read data register, later beats one clock each
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            // Nothing to drive after reset
            rdata_q <= {DATA_W{1'b0}};
            rpar_q <= {LANES{1'b0}};
            rvalid_q <= 1'b0;
        end else if (do_read) begin
            // Data and parity at the current beat address
            rdata_q <= mem[cur_addr][DATA_W-1:0];
            rpar_q <= mem[cur_addr][WW-1:DATA_W];
            rvalid_q <= 1'b1;
        end else begin
            // Data holds, valid drops after one cycle
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Read data and parity straight from their registers
    assign DQ_OUT = rdata_q;
    assign PARITY_IO_OUT = rpar_q;
    // Drive needs the output enable pin, a read beat and the part awake
    // Low only while a beat stands, the pin allows it and the part is awake
    assign DQ_OE_N = !(rvalid_q && !OUTPUT_EN_N && !asleep);
    // Sleep status mirrors the pin
    assign SLEEPING = asleep;
    // One pulse per read beat
    assign BEAT_VALID = rvalid_q;
endmodule

/* File: bench/sbsp_port_properties.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module sbsp_chk #(parameter DATA_W = 32) (
    input wire CLK, NRST, PROC_ADDR_STROBE_N, CTRL_ADDR_STROBE_N, BURST_ADVANCE_N,
    input wire CHIP_SEL_PIPELINED_N, CHIP_SEL_DEPTH_HI, CHIP_SEL_DEPTH_LO_N,
    input wire BYTE_WRITE_GATE_N, GLOBAL_WRITE_N, OUTPUT_EN_N, SLEEP_REQUEST,
    input wire [DATA_W-1:0] DQ_OUT,
    input wire DQ_OE_N, SLEEPING, BEAT_VALID
);
    // All three selects active, awake
    wire sel = !CHIP_SEL_PIPELINED_N && CHIP_SEL_DEPTH_HI && !CHIP_SEL_DEPTH_LO_N &&
        !SLEEP_REQUEST;
    // Beat edge after a start: no write control, no strobe, awake
    wire rd_edge = GLOBAL_WRITE_N && BYTE_WRITE_GATE_N && PROC_ADDR_STROBE_N &&
        CTRL_ADDR_STROBE_N && !SLEEP_REQUEST;
    // No strobe and no advance
    wire quiet = BURST_ADVANCE_N && PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    oe_gate_a: assert property (!DQ_OE_N |-> !OUTPUT_EN_N && !SLEEP_REQUEST)
        else $error("bus driven while disabled");
    sleep_flag_a: assert property (SLEEPING == SLEEP_REQUEST)
        else $error("sleep flag off pin");
    ctrl_start_a: assert property (sel && !CTRL_ADDR_STROBE_N ##1 rd_edge
        |-> ##1 BEAT_VALID) else $error("no beat after strobe");
    proc_start_a: assert property (sel && !PROC_ADDR_STROBE_N ##1 rd_edge
        |-> ##1 BEAT_VALID) else $error("no beat after processor strobe");
    quiet_bus_a: assert property (quiet [*4] |-> !BEAT_VALID)
        else $error("beat without advance");
    sleep_block_a: assert property (SLEEP_REQUEST [*3] |-> !BEAT_VALID)
        else $error("beat while asleep");
    hold_data_a: assert property (!BEAT_VALID |-> $stable(DQ_OUT))
        else $error("read data moved between beats");
    beat_drive_a: assert property (BEAT_VALID && !OUTPUT_EN_N && !SLEEP_REQUEST
        |-> !DQ_OE_N) else $error("beat not driven");
endmodule
bind sbsp_port sbsp_chk #(.DATA_W(DATA_W)) chk_u (.CLK(CLK), .NRST(NRST),
    .PROC_ADDR_STROBE_N(PROC_ADDR_STROBE_N), .CTRL_ADDR_STROBE_N(CTRL_ADDR_STROBE_N),
    .BURST_ADVANCE_N(BURST_ADVANCE_N), .CHIP_SEL_PIPELINED_N(CHIP_SEL_PIPELINED_N),
    .CHIP_SEL_DEPTH_HI(CHIP_SEL_DEPTH_HI), .CHIP_SEL_DEPTH_LO_N(CHIP_SEL_DEPTH_LO_N),
    .BYTE_WRITE_GATE_N(BYTE_WRITE_GATE_N), .GLOBAL_WRITE_N(GLOBAL_WRITE_N),
    .OUTPUT_EN_N(OUTPUT_EN_N), .SLEEP_REQUEST(SLEEP_REQUEST), .DQ_OUT(DQ_OUT),
    .DQ_OE_N(DQ_OE_N), .SLEEPING(SLEEPING), .BEAT_VALID(BEAT_VALID));

/* File: bench/sbsp_host.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Bus master side of the shared data bus
// ----------------------------------------
module sbsp_host #(parameter DATA_W = 32) (
    input wire clk,
    input wire [DATA_W-1:0] dq_out,
    input wire dq_oe_n,
    input wire wr_en,
    input wire [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] dq_in
);
    // Last wire level, inverted when nobody drives
    logic [DATA_W-1:0] last_q = {DATA_W{1'b0}};
    always @(posedge clk) last_q <= dq_in;
    // Wire level from both parties, write data clock-aligned
    always @* dq_in = !dq_oe_n ? dq_out : (wr_en ? wr_data : ~last_q);
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ns
module tb;
    reg clk = 1'b0, nrst = 1'b0, psn = 1'b1, csn = 1'b1, advn = 1'b1, ce1n = 1'b0;
    reg ce2 = 1'b1, ce3n = 1'b0, gwn = 1'b1, bwen = 1'b1, mode = 1'b1, oen = 1'b1;
    reg zz = 1'b0, wen = 1'b0;
    reg [5:0] addr = 6'h00;
    reg [3:0] bwn = 4'hF;
    reg [31:0] wd = 32'h0;
    wire [31:0] dq_in, dq_out;
    wire [3:0] par;
    wire oe_n, sleeping, beat;
    int fails = 0, compares = 0, cyc = 0, k;
    reg [35:0] got[$];
    reg [35:0] mdl [0:63]; // Expected array contents, parity on top
    int at[$];
    always #5 clk = ~clk;
    // Beat capture and run limit
    always @(posedge clk) begin
        cyc++;
        if (beat) begin
            got.push_back({par, dq_out});
            at.push_back(cyc);
        end
        if (cyc > 3000) begin
            fails++;
            tally_and_finish;
        end
    end
    sbsp_port #(.ADDR_W(6)) dut_u (.CLK(clk), .NRST(nrst), .ADDR(addr),
        .PROC_ADDR_STROBE_N(psn), .CTRL_ADDR_STROBE_N(csn), .BURST_ADVANCE_N(advn),
        .CHIP_SEL_PIPELINED_N(ce1n), .CHIP_SEL_DEPTH_HI(ce2), .CHIP_SEL_DEPTH_LO_N(ce3n),
        .BYTE_WRITE_LANE_N(bwn), .BYTE_WRITE_GATE_N(bwen), .GLOBAL_WRITE_N(gwn),
        .BURST_ORDER(mode), .OUTPUT_EN_N(oen), .SLEEP_REQUEST(zz), .DQ_IN(dq_in),
        .DQ_OUT(dq_out), .DQ_OE_N(oe_n), .PARITY_IO_IN(wd[3:0]), .PARITY_IO_OUT(par),
        .SLEEPING(sleeping), .BEAT_VALID(beat));
    sbsp_host host_u (.clk(clk), .dq_out(dq_out), .dq_oe_n(oe_n), .wr_en(wen),
        .wr_data(wd), .dq_in(dq_in));
    task check(input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single-beat write: global when lanes_n is zero, else byte gate
    task wr(input [5:0] a, input [3:0] lanes_n);
        reg [31:0] d;
        d = {26'h2A5C3E1, a} ^ {32{lanes_n != 4'h0}};
        @(posedge clk);
        addr <= a;
        csn <= 1'b0;
        @(posedge clk);
        csn <= 1'b1;
        wen <= 1'b1;
        wd <= d;
        if (lanes_n == 4'h0) gwn <= 1'b0;
        else begin
            bwen <= 1'b0;
            bwn <= lanes_n;
        end
        // Expected contents, lane by lane, parity from the low data bits
        for (k = 0; k < 4; k++) begin
            if (lanes_n == 4'h0 || !lanes_n[k]) begin
                mdl[a][k*8 +: 8] = d[k*8 +: 8];
                mdl[a][32+k] = d[k];
            end
        end
        @(posedge clk);
        gwn <= 1'b1;
        bwen <= 1'b1;
        bwn <= 4'hF;
        wen <= 1'b0;
    endtask
    // Four-beat read, order pin flipped after start
    task rd(input [5:0] a, input o, input p);
        reg [1:0] lo;
        got.delete();
        at.delete();
        @(posedge clk);
        addr <= a;
        mode <= o;
        if (p) psn <= 1'b0;
        else csn <= 1'b0;
        @(posedge clk);
        psn <= 1'b1;
        csn <= 1'b1;
        advn <= 1'b0;
        mode <= ~o;
        repeat (3) @(posedge clk);
        advn <= 1'b1;
        repeat (4) @(posedge clk);
        check(got.size(), 4);
        for (k = 0; k < 4 && k < got.size(); k++) begin
            lo = o ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
            check(got[k][31:0], mdl[{a[5:2], lo}][31:0]);
            check(got[k][35:32], mdl[{a[5:2], lo}][35:32]);
            if (k > 0) check(at[k] - at[k-1], 1);
        end
    endtask
    task tally_and_finish;
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++) wr(i[5:0], 4'h0);
        oen <= 1'b0;
        rd(6'h01, 1'b1, 1'b0);
        // Lanes 0 and 2 rewritten through the byte gate
        wr(6'h05, 4'hA);
        rd(6'h06, 1'b0, 1'b0);
        rd(6'h07, 1'b1, 1'b1);
        rd(6'h02, 1'b0, 1'b1);
        // Deselected start gives nothing
        got.delete();
        @(posedge clk);
        ce2 <= 1'b0;
        csn <= 1'b0;
        @(posedge clk);
        csn <= 1'b1;
        ce2 <= 1'b1;
        repeat (4) @(posedge clk);
        check(got.size(), 0);
        // Sleep right after a start ends the burst
        @(posedge clk);
        addr <= 6'h00;
        csn <= 1'b0;
        @(posedge clk);
        csn <= 1'b1;
        advn <= 1'b0;
        zz <= 1'b1;
        repeat (3) @(posedge clk);
        check(sleeping, 1'b1);
        check(oe_n, 1'b1);
        zz <= 1'b0;
        advn <= 1'b1;
        repeat (4) @(posedge clk);
        check(got.size(), 0);
        tally_and_finish;
    end
endmodule
